// ==== design/cord_defines.svh ====
// Offsets, reset values and divider constants of the clock output and rate dividers
`ifndef CORD_DEFINES_SVH
`define CORD_DEFINES_SVH

`define CORD_ADDR_CLK_DIV 8'h01
`define CORD_ADDR_TX_HIGH 8'h02
`define CORD_ADDR_TX_LOW 8'h03
`define CORD_ADDR_RX1_HIGH 8'h04
`define CORD_ADDR_RX1_LOW 8'h05
`define CORD_ADDR_RX_OVS 8'h06
`define CORD_ADDR_RSVD_SEVEN 8'h07
`define CORD_ADDR_LOW_RATE 8'h20

`define CORD_RST_CLK_DIV 8'h05
`define CORD_RST_TX_HIGH 8'h00
`define CORD_RST_TX_LOW 8'h12
`define CORD_RST_RX1_HIGH 8'h00
`define CORD_RST_RX1_LOW 8'h09
`define CORD_RST_RX_OVS 7'h0a
`define CORD_RST_RSVD_SEVEN 8'h5e
`define CORD_RST_LOW_RATE 1'b0

`define CORD_LOW_RATE_BIT 0
`define CORD_OVS_MSB 6

`define CORD_OUT_MUL 12'h010
`define CORD_OUT_ADD 12'h002
`define CORD_HALF_PERIOD 12'h002
`define CORD_THIRD_PERIOD 12'h003
`define CORD_THIRD_HIGH 12'h001
`define CORD_RST_PERIOD 12'h002
`define CORD_RST_HIGH 12'h001

`define CORD_TX_PRESCALE 4'ha
`define CORD_OVS_ZERO_FACTOR 8'h80

`endif

// ==== design/cord_pkg.sv ====
// Types shared by the clock output and rate divider block
package cord_pkg;

    typedef logic [7:0] cord_byte_type;
    typedef logic [15:0] cord_word_type;
    typedef logic [11:0] cord_period_type;

    typedef enum logic [1:0]
    {
        cord_mode_pass,
        cord_mode_half,
        cord_mode_third,
        cord_mode_formula
    } cord_div_mode_type;

endpackage

// ==== design/cord_clk_div.sv ====
// Free-running clock divider with period and high time taken at each wrap
`timescale 1ns/100ps
`include "cord_defines.svh"

module cord_clk_div
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    // Wanted waveform
    input wire cord_pkg::cord_period_type period_in,
    input wire cord_pkg::cord_period_type high_in,
    // Divided clock
    output logic div_clk_out
);

    cord_pkg::cord_period_type cnt_q;
    cord_pkg::cord_period_type cnt_d;
    cord_pkg::cord_period_type period_q;
    cord_pkg::cord_period_type high_q;
    cord_pkg::cord_period_type high_now;
    logic out_q;
    logic out_d;
    wire wrap = (cnt_q >= period_q - 12'h001);

    // New setting only at a period boundary, so the output never stops or shortens a phase
    assign cnt_d = wrap ? 12'h000 : cnt_q + 12'h001;
    assign high_now = wrap ? high_in : high_q;
    assign out_d = (cnt_d < high_now);
    assign div_clk_out = out_q;

    always_ff @(posedge core_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            cnt_q <= 12'h000;
            period_q <= `CORD_RST_PERIOD;
            high_q <= `CORD_RST_HIGH;
            out_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            out_q <= out_d;
            if (wrap)
            begin
                period_q <= period_in;
                high_q <= high_in;
            end
        end
    end

endmodule

// ==== design/cord_top.sv ====
// Clock output divider and transmit/receive data rate dividers with their registers
// Behaviour
// - Codes 0,1,2 give full, half, third clock
// - Other codes divide by sixteen times code plus two
// - Transmit divisor is high byte then low byte
// - Receive divisor one joins high and low bytes
// - Halving bit selects N of one or two
// - Oversampling field zero means factor 128
`timescale 1ns/100ps
`include "cord_defines.svh"

module cord_top
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    // Register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // Divided clock pin
    output logic divided_clock_pin_out,
    // Rate strobes
    output logic tx_bit_tick_out,
    output logic rx_sample_tick_out,
    output logic rx_bit_tick_out,
    // Effective settings
    output logic [15:0] tx_rate_divisor_out,
    output logic [15:0] receive_rate_divisor_one_out,
    output logic [7:0] receive_oversample_factor_out
);

    function automatic cord_pkg::cord_div_mode_type cord_mode_of(input cord_pkg::cord_byte_type code);
        if (code == 8'h00)
            return cord_pkg::cord_mode_pass;
        else if (code == 8'h01)
            return cord_pkg::cord_mode_half;
        else if (code == 8'h02)
            return cord_pkg::cord_mode_third;
        else
            return cord_pkg::cord_mode_formula;
    endfunction

    // A divisor of zero is taken as one so the strobe never freezes
    function automatic logic cord_at_limit(input cord_pkg::cord_word_type cnt, input cord_pkg::cord_word_type lim);
        if (lim == 16'h0000)
            return 1'b1;
        else
            return (cnt >= lim - 16'h0001);
    endfunction

    // Registers
    cord_pkg::cord_byte_type clk_div_q;
    cord_pkg::cord_byte_type tx_high_q;
    cord_pkg::cord_byte_type tx_low_q;
    cord_pkg::cord_byte_type rx1_high_q;
    cord_pkg::cord_byte_type rx1_low_q;
    logic [6:0] rx_ovs_q;
    cord_pkg::cord_byte_type rsvd_seven_q;
    logic low_rate_q;
    cord_pkg::cord_byte_type rdata_q;

    // Address decode
    wire sel_clk_div = (reg_addr_in == `CORD_ADDR_CLK_DIV);
    wire sel_tx_high = (reg_addr_in == `CORD_ADDR_TX_HIGH);
    wire sel_tx_low = (reg_addr_in == `CORD_ADDR_TX_LOW);
    wire sel_rx1_high = (reg_addr_in == `CORD_ADDR_RX1_HIGH);
    wire sel_rx1_low = (reg_addr_in == `CORD_ADDR_RX1_LOW);
    wire sel_rx_ovs = (reg_addr_in == `CORD_ADDR_RX_OVS);
    wire sel_rsvd = (reg_addr_in == `CORD_ADDR_RSVD_SEVEN);
    wire sel_low_rate = (reg_addr_in == `CORD_ADDR_LOW_RATE);
    cord_pkg::cord_byte_type rdata_d;

    // Unmapped addresses read as zero; bit 7 of the oversampling register is reserved
    always_comb
    begin
        if (sel_clk_div)
            rdata_d = clk_div_q;
        else if (sel_tx_high)
            rdata_d = tx_high_q;
        else if (sel_tx_low)
            rdata_d = tx_low_q;
        else if (sel_rx1_high)
            rdata_d = rx1_high_q;
        else if (sel_rx1_low)
            rdata_d = rx1_low_q;
        else if (sel_rx_ovs)
            rdata_d = {1'b0, rx_ovs_q};
        else if (sel_rsvd)
            rdata_d = rsvd_seven_q;
        else if (sel_low_rate)
            rdata_d = {7'h00, low_rate_q};
        else
            rdata_d = 8'h00;
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            clk_div_q <= `CORD_RST_CLK_DIV;
            tx_high_q <= `CORD_RST_TX_HIGH;
            tx_low_q <= `CORD_RST_TX_LOW;
            rx1_high_q <= `CORD_RST_RX1_HIGH;
            rx1_low_q <= `CORD_RST_RX1_LOW;
            rx_ovs_q <= `CORD_RST_RX_OVS;
            rsvd_seven_q <= `CORD_RST_RSVD_SEVEN;
            low_rate_q <= `CORD_RST_LOW_RATE;
        end
        else if (reg_wr_in)
        begin
            if (sel_clk_div)
                clk_div_q <= reg_wdata_in;
            if (sel_tx_high)
                tx_high_q <= reg_wdata_in;
            if (sel_tx_low)
                tx_low_q <= reg_wdata_in;
            if (sel_rx1_high)
                rx1_high_q <= reg_wdata_in;
            if (sel_rx1_low)
                rx1_low_q <= reg_wdata_in;
            if (sel_rx_ovs)
                rx_ovs_q <= reg_wdata_in[`CORD_OVS_MSB:0];
            if (sel_rsvd)
                rsvd_seven_q <= reg_wdata_in;
            if (sel_low_rate)
                low_rate_q <= reg_wdata_in[`CORD_LOW_RATE_BIT];
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            rdata_q <= 8'h00;
        else if (reg_rd_in)
            rdata_q <= rdata_d;
        else
            rdata_q <= 8'h00;
    end

    assign reg_rdata_out = rdata_q;

    // Clock output waveform
    cord_pkg::cord_div_mode_type mode;
    cord_pkg::cord_period_type formula_period;
    cord_pkg::cord_period_type period;
    cord_pkg::cord_period_type high;
    logic pass_q;
    logic div_clk;

    assign mode = cord_mode_of(clk_div_q);
    assign formula_period = 12'({4'h0, clk_div_q} * `CORD_OUT_MUL) + `CORD_OUT_ADD;

    always_comb
    begin
        case (mode)
            cord_pkg::cord_mode_half:
            begin
                period = `CORD_HALF_PERIOD;
                high = `CORD_HALF_PERIOD >> 1;
            end
            cord_pkg::cord_mode_third:
            begin
                period = `CORD_THIRD_PERIOD;
                high = `CORD_THIRD_HIGH;
            end
            cord_pkg::cord_mode_formula:
            begin
                period = formula_period;
                high = formula_period >> 1;
            end
            default:
            begin
                period = `CORD_HALF_PERIOD;
                high = `CORD_HALF_PERIOD >> 1;
            end
        endcase
    end

    cord_clk_div u_clk_div
    (
        .core_clk_in(core_clk_in),
        .rst_b_in(rst_b_in),
        .period_in(period),
        .high_in(high),
        .div_clk_out(div_clk)
    );

    always_ff @(posedge core_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            pass_q <= 1'b0;
        else
            pass_q <= (mode == cord_pkg::cord_mode_pass);
    end

    // Full-rate code forwards the clock itself; switching in or out can give one short phase
    assign divided_clock_pin_out = pass_q ? core_clk_in : div_clk;

    // Rate dividers
    cord_pkg::cord_word_type tx_div;
    cord_pkg::cord_word_type rx_div;
    cord_pkg::cord_byte_type ovs_factor;
    logic [3:0] tx_pre_q;
    cord_pkg::cord_word_type tx_cnt_q;
    logic half_q;
    cord_pkg::cord_word_type rx_cnt_q;
    cord_pkg::cord_byte_type ovs_cnt_q;
    logic tx_tick_q;
    logic rx_sample_q;
    logic rx_bit_q;

    assign tx_div = {tx_high_q, tx_low_q};
    assign rx_div = {rx1_high_q, rx1_low_q};
    assign ovs_factor = (rx_ovs_q == 7'h00) ? `CORD_OVS_ZERO_FACTOR : {1'b0, rx_ovs_q};

    // Transmit bit period is ten clocks times the divisor
    wire tx_pre_wrap = (tx_pre_q == `CORD_TX_PRESCALE - 4'h1);
    wire tx_wrap = tx_pre_wrap && cord_at_limit(tx_cnt_q, tx_div);
    // Halving bit lets the receive counter advance on every second clock
    wire rx_step = !low_rate_q || half_q;
    wire rx_wrap = rx_step && cord_at_limit(rx_cnt_q, rx_div);
    wire ovs_wrap = rx_wrap && cord_at_limit({8'h00, ovs_cnt_q}, {8'h00, ovs_factor});

    always_ff @(posedge core_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            tx_pre_q <= 4'h0;
            tx_cnt_q <= 16'h0000;
            half_q <= 1'b0;
            rx_cnt_q <= 16'h0000;
            ovs_cnt_q <= 8'h00;
            tx_tick_q <= 1'b0;
            rx_sample_q <= 1'b0;
            rx_bit_q <= 1'b0;
        end
        else
        begin
            tx_pre_q <= tx_pre_wrap ? 4'h0 : tx_pre_q + 4'h1;
            if (tx_pre_wrap)
                tx_cnt_q <= tx_wrap ? 16'h0000 : tx_cnt_q + 16'h0001;
            half_q <= low_rate_q ? !half_q : 1'b0;
            if (rx_step)
                rx_cnt_q <= rx_wrap ? 16'h0000 : rx_cnt_q + 16'h0001;
            if (rx_wrap)
                ovs_cnt_q <= ovs_wrap ? 8'h00 : ovs_cnt_q + 8'h01;
            tx_tick_q <= tx_wrap;
            rx_sample_q <= rx_wrap;
            rx_bit_q <= ovs_wrap;
        end
    end

    assign tx_bit_tick_out = tx_tick_q;
    assign rx_sample_tick_out = rx_sample_q;
    assign rx_bit_tick_out = rx_bit_q;
    assign tx_rate_divisor_out = tx_div;
    assign receive_rate_divisor_one_out = rx_div;
    assign receive_oversample_factor_out = ovs_factor;

endmodule

// ==== testbench/cord_top_monitor.sv ====
// Port-level assertions for cord_top
`timescale 1ns/100ps
module cord_top_chk
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    // Register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    // Outputs
    input wire logic divided_clock_pin_out,
    input wire logic tx_bit_tick_out,
    input wire logic rx_sample_tick_out,
    input wire logic rx_bit_tick_out,
    input wire logic [15:0] tx_rate_divisor_out,
    input wire logic [15:0] receive_rate_divisor_one_out,
    input wire logic [7:0] receive_oversample_factor_out
);
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_b_in);
    wire wr_ovs = reg_wr_in && reg_addr_in == 8'h06;
    chk_tx_high_byte: assert property (reg_wr_in && reg_addr_in == 8'h02 |=>
        tx_rate_divisor_out[15:8] == $past(reg_wdata_in)) else $error("tx high byte not applied");
    chk_tx_low_byte: assert property (reg_wr_in && reg_addr_in == 8'h03 |=>
        tx_rate_divisor_out[7:0] == $past(reg_wdata_in)) else $error("tx low byte not applied");
    chk_rx_high_byte: assert property (reg_wr_in && reg_addr_in == 8'h04 |=>
        receive_rate_divisor_one_out[15:8] == $past(reg_wdata_in)) else $error("rx high byte not applied");
    chk_ovs_zero_factor: assert property (wr_ovs && reg_wdata_in[6:0] == 7'h00 |=>
        receive_oversample_factor_out == 8'h80) else $error("zero factor not 128");
    chk_ovs_plain_factor: assert property (wr_ovs && reg_wdata_in[6:0] != 7'h00 |=>
        receive_oversample_factor_out == {1'b0, $past(reg_wdata_in[6:0])}) else $error("factor wrong");
    chk_tx_low_read: assert property (reg_rd_in && reg_addr_in == 8'h03 |=>
        reg_rdata_out == $past(tx_rate_divisor_out[7:0])) else $error("tx low readback wrong");
    chk_tx_tick_gap: assert property (tx_bit_tick_out |=> !tx_bit_tick_out [*8])
        else $error("tx ticks too close");
    chk_bit_on_sample: assert property (rx_bit_tick_out |-> rx_sample_tick_out)
        else $error("bit tick off sample tick");
    cover property (wr_ovs && reg_wdata_in[6:0] == 7'h00);
    cover property (rx_bit_tick_out);
    cover property ($rose(divided_clock_pin_out));
endmodule

bind cord_top cord_top_chk u_chk (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .divided_clock_pin_out(divided_clock_pin_out), .tx_bit_tick_out(tx_bit_tick_out),
    .rx_sample_tick_out(rx_sample_tick_out), .rx_bit_tick_out(rx_bit_tick_out),
    .tx_rate_divisor_out(tx_rate_divisor_out), .receive_rate_divisor_one_out(receive_rate_divisor_one_out),
    .receive_oversample_factor_out(receive_oversample_factor_out));

// ==== testbench/cord_host_model.sv ====
// Host software model driving the register port
`timescale 1ns/100ps
module cord_host_model
#(
    parameter int CLK_HZ = 125_000_000
)
(
    input wire logic core_clk_in,
    output logic [7:0] addr_out,
    output logic [7:0] wdata_out,
    output logic wr_out,
    output logic rd_out,
    input wire logic [7:0] rdata_in
);
    initial
    begin
        addr_out = 8'h00;
        wdata_out = 8'h00;
        wr_out = 1'b0;
        rd_out = 1'b0;
    end
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        // Factors 1 to 29 are never issued
        if (a == 8'h06 && d[6:0] >= 7'h01 && d[6:0] <= 7'h1d)
            return;
        @(posedge core_clk_in);
        addr_out <= a;
        wdata_out <= d;
        wr_out <= 1'b1;
        @(posedge core_clk_in);
        wr_out <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk_in);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge core_clk_in);
        rd_out <= 1'b0;
        @(posedge core_clk_in);
        d = rdata_in;
    endtask
    function automatic int tx_div(input int rate);
        return (CLK_HZ / 10 + rate / 2) / rate;
    endfunction
    function automatic int rx_div(input int rate, input int factor, input int n);
        return (CLK_HZ / n + rate * factor / 2) / (rate * factor);
    endfunction
endmodule

// ==== testbench/test_clock_out_and_rate_dividers.sv ====
// Self-checking bench for the clock output and rate dividers
`timescale 1ns/100ps
module test_clock_out_and_rate_dividers;
    logic core_clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, ovs, rd;
    logic reg_wr, reg_rd, pin, tx_tick, rx_samp, rx_bit;
    logic [15:0] tx_div, rx_div;
    int err_total = 0;
    int num_checks = 0;
    always #4 core_clk_in = ~core_clk_in;
    cord_host_model u_host (.core_clk_in(core_clk_in), .addr_out(reg_addr), .wdata_out(reg_wdata),
        .wr_out(reg_wr), .rd_out(reg_rd), .rdata_in(reg_rdata));
    cord_top u_dut (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr),
        .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata),
        .divided_clock_pin_out(pin), .tx_bit_tick_out(tx_tick), .rx_sample_tick_out(rx_samp),
        .rx_bit_tick_out(rx_bit), .tx_rate_divisor_out(tx_div), .receive_rate_divisor_one_out(rx_div),
        .receive_oversample_factor_out(ovs));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            err_total++;
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        u_host.rd_reg(a, rd);
        chk({8'h00, rd}, {8'h00, exp});
    endtask
    // Syncs on one tick, then counts to the next; bounded so a dead tick shows as a mismatch
    task automatic gap(input int sel, output int n);
        for (int k = 0; k < 2; k++)
        begin
            n = 0;
            do
            begin
                @(negedge core_clk_in);
                n++;
            end while ((sel == 0 ? tx_tick : sel == 1 ? rx_samp : rx_bit) !== 1'b1 && n < 3000);
        end
    endtask
    task automatic pin_hl(output int h, output int l);
        h = 0;
        l = 0;
        for (int k = 0; k < 200 && pin !== 1'b0; k++) @(negedge core_clk_in);
        for (int k = 0; k < 200 && pin !== 1'b1; k++) @(negedge core_clk_in);
        for (; pin === 1'b1 && h < 200; h++) @(negedge core_clk_in);
        for (; pin === 1'b0 && l < 200; l++) @(negedge core_clk_in);
    endtask
    task automatic t_regs();
        logic [7:0] a[9] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h20, 8'h30};
        logic [7:0] e[9] = '{8'h05, 8'h00, 8'h12, 8'h00, 8'h09, 8'h0a, 8'h5e, 8'h00, 8'h00};
        for (int i = 0; i < 9; i++) rd_chk(a[i], e[i]);
        u_host.wr_reg(8'h07, 8'ha5);
        u_host.wr_reg(8'h30, 8'hff);
        u_host.wr_reg(8'h06, 8'h9e);
        rd_chk(8'h07, 8'ha5);
        rd_chk(8'h30, 8'h00);
        rd_chk(8'h06, 8'h1e);
    endtask
    task automatic t_pin();
        int c[4] = '{1, 2, 3, 5};
        int eh[4] = '{1, 1, 25, 41};
        int el[4] = '{1, 2, 25, 41};
        int h, l;
        u_host.wr_reg(8'h01, 8'h00);
        repeat (100) @(posedge core_clk_in);
        #1 chk(pin, 1'b1);
        @(negedge core_clk_in);
        #1 chk(pin, 1'b0);
        for (int i = 0; i < 4; i++)
        begin
            u_host.wr_reg(8'h01, c[i][7:0]);
            repeat (100) @(posedge core_clk_in);
            pin_hl(h, l);
            chk(h[15:0], eh[i][15:0]);
            chk(l[15:0], el[i][15:0]);
        end
    endtask
    task automatic t_tx();
        int d, n;
        d = u_host.tx_div(4_166_667);
        u_host.wr_reg(8'h02, 8'h01);
        u_host.wr_reg(8'h03, d[7:0]);
        // Write lands at the edge the task returns on; look once it has settled
        @(negedge core_clk_in);
        chk(tx_div, {8'h01, d[7:0]});
        u_host.wr_reg(8'h02, 8'h00);
        gap(0, n);
        chk(n[15:0], 16'(10 * d));
    endtask
    task automatic t_rx();
        int d, n;
        d = u_host.rx_div(833_333, 30, 1);
        u_host.wr_reg(8'h04, 8'h00);
        u_host.wr_reg(8'h05, d[7:0]);
        u_host.wr_reg(8'h06, 8'h1e);
        chk(rx_div, 16'h0005);
        gap(1, n);
        chk(n[15:0], 16'(d));
        gap(2, n);
        chk(n[15:0], 16'(30 * d));
        u_host.wr_reg(8'h20, 8'h01);
        gap(1, n);
        chk(n[15:0], 16'(2 * d));
        u_host.wr_reg(8'h06, 8'h00);
        @(negedge core_clk_in);
        chk(ovs, 16'h0080);
        gap(2, n);
        chk(n[15:0], 16'(256 * d));
        u_host.wr_reg(8'h20, 8'h00);
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        #(8 * 40000);
        err_total++;
        complete_run();
    end
    initial
    begin
        repeat (8) @(posedge core_clk_in);
        rst_b_in <= 1'b1;
        t_regs();
        t_pin();
        t_tx();
        t_rx();
        complete_run();
    end
endmodule
